// ===== stc_map.svh
// register map, field positions, reset values and timing figures of the stepper control block
`ifndef STC_MAP_SVH
`define STC_MAP_SVH
// What this block does
// - reset input high forces initial electrical angle
// - reset input pulses under 0.625 us ignored
// - reset holds 100% full step, else 71%
// - origin monitor output low during reset
// - torque select scales current 100% to 10%
// - edge select: rising only, or both edges
// - sense select: internal or external resistor sensing
// - gain select: reference gain 1/5 or 1/10
// - decay select: 6 clocks, 8 clocks, fast, adaptive
// - chopping cycle lasts sixteen oscillator clocks
// - slow decay fills the rest of cycle
// - current limit trip ends charge period
// - charge extends past cycle until trip
// - mixed decay is fast then slow

// register byte offsets on the bus
`define STC_CTRL_ADDR     8'h00
`define STC_STAT_ADDR     8'h04
`define STC_TGT_ADDR      8'h08
`define STC_CTRL_RST      12'h000
// control register field positions
`define STC_F_RES         2:0
`define STC_F_TORQUE      5:3
`define STC_F_EDGE        6
`define STC_F_SENSE       7
`define STC_F_GAIN        8
`define STC_F_DECAY       10:9
`define STC_F_DIR         11
// status and target register field positions
`define STC_F_ANGLE       8:0
`define STC_F_ORIGIN      9
`define STC_F_RSTACT      10
`define STC_F_STATE_A     12:11
`define STC_F_STATE_B     14:13
`define STC_F_TGT_A       9:0
`define STC_F_TGT_B       25:16
// timing and scaling figures
`define STC_CLK_MHZ       50
`define STC_RST_FILT_NS   625
`define STC_CHOP_TICKS    16
`define STC_FAST_375      4'h6
`define STC_FAST_50       4'h8
`define STC_ANGLE_INIT    9'h040
`define STC_FULL_STEP_INC 9'h080
`define STC_FULL_PCT      7'h64
`define STC_PCT_SQ        24'h00_2710
`define STC_CODE_FULL     24'h00_03FF
`endif

// ===== stc_pkg.sv
// shared types of the stepper control block
package stc_pkg;
	typedef enum logic [1:0] {
		STC_CHARGE = 2'b00,
		STC_FAST   = 2'b01,
		STC_SLOW   = 2'b10
	} stc_chop_state_t;
	typedef enum logic [1:0] {
		STC_MIX_375  = 2'b00,
		STC_MIX_50   = 2'b01,
		STC_FAST_ONLY = 2'b10,
		STC_ADAPTIVE = 2'b11
	} stc_decay_t;
endpackage

// ===== stc_chop_if.sv
// signals between the control core and one channel chopper
`timescale 1ns/1ps
interface stc_chop_if;
	import stc_pkg::*;
	logic [9:0]      target;
	logic [9:0]      sense;
	stc_decay_t      decay_sel;
	logic            osc_tick;
	logic            cyc_start;
	logic            trip;
	stc_chop_state_t state;
	modport chop (input target, sense, decay_sel, osc_tick, cyc_start, output trip, state);
	modport ctl  (output target, sense, decay_sel, osc_tick, cyc_start, input trip, state);
endinterface

// ===== stc_step_table.sv
// quarter-wave microstep table: angle index to per-channel magnitude and sign
`timescale 1ns/1ps
`include "stc_map.svh"
module stc_step_table (
	input  wire logic [8:0] angle,
	input  wire logic [2:0] res,
	output logic      [6:0] mag_a,
	output logic      [6:0] mag_b,
	output logic            neg_a,
	output logic            neg_b
);
	// cosine in percent at every sixteenth of a quarter
	function automatic logic [6:0] stc_pt(input logic [4:0] k);
		case (k)
			5'h00, 5'h01: stc_pt = 7'h64;
			5'h02: stc_pt = 7'h62;
			5'h03: stc_pt = 7'h60;
			5'h04: stc_pt = 7'h5C;
			5'h05: stc_pt = 7'h58;
			5'h06: stc_pt = 7'h53;
			5'h07: stc_pt = 7'h4D;
			5'h08: stc_pt = 7'h47;
			5'h09: stc_pt = 7'h3F;
			5'h0A: stc_pt = 7'h38;
			5'h0B: stc_pt = 7'h2F;
			5'h0C: stc_pt = 7'h26;
			5'h0D: stc_pt = 7'h1D;
			5'h0E: stc_pt = 7'h14;
			5'h0F: stc_pt = 7'h0A;
			default: stc_pt = 7'h00;
		endcase
	endfunction

	// finer points interpolate linearly; costs a percent of accuracy, saves a 129-entry rom
	function automatic logic [6:0] stc_cos(input logic [7:0] x);
		logic [6:0] d;
		d = stc_pt(x[7:3]) - stc_pt(x[7:3] + 5'h01);
		stc_cos = stc_pt(x[7:3]) - 7'((10'(d) * 10'(x[2:0])) >> 3);
	endfunction

	logic [7:0] w;
	logic [7:0] wr;
	assign w  = {1'b0, angle[6:0]};
	assign wr = 8'h80 - w;

	// full step runs at full current, finer resolutions follow the sine table
	always_comb begin
		if (res == 3'h0) begin
			mag_a = `STC_FULL_PCT;
			mag_b = `STC_FULL_PCT;
		end else if (angle[7] == 1'b0) begin
			mag_a = stc_cos(w);
			mag_b = stc_cos(wr);
		end else begin
			mag_a = stc_cos(wr);
			mag_b = stc_cos(w);
		end
	end
	assign neg_a = angle[8] ^ angle[7];
	assign neg_b = angle[8];
endmodule

// ===== stc_chopper.sv
// one channel constant-current chopper: charge, fast decay, slow decay
`timescale 1ns/1ps
`include "stc_map.svh"
module stc_chopper
	import stc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	stc_chop_if.chop cif
);
	stc_chop_state_t state_q;
	logic            trip_q;
	logic [3:0]      fast_q;

	// compare registered so the trip is a clean flop output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trip_q <= 1'b0;
		end else begin
			trip_q <= (cif.sense >= cif.target);
		end
	end

	// fast decay first, then slow decay for the rest of the cycle unless fast-only decay is selected
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= STC_CHARGE;
			fast_q  <= 4'h0;
		end else begin
			case (state_q)
				STC_CHARGE: begin // a cycle start never cuts charge short
					// leave on the first oscillator tick after the trip so fast decay spans
					// whole oscillator periods; costs up to one period of extra charge
					if (trip_q && cif.osc_tick) begin
						state_q <= STC_FAST;
						fast_q  <= (cif.decay_sel == STC_MIX_375) ? `STC_FAST_375 : `STC_FAST_50;
					end
				end
				STC_FAST: begin
					if (cif.cyc_start) begin
						state_q <= STC_CHARGE;
					end else if (cif.decay_sel == STC_ADAPTIVE) begin
						if (!trip_q) begin
							state_q <= STC_SLOW;
						end
					end else if (cif.decay_sel != STC_FAST_ONLY && cif.osc_tick) begin
						fast_q <= fast_q - 4'h1;
						if (fast_q == 4'h1) begin
							state_q <= STC_SLOW;
						end
					end
				end
				STC_SLOW: begin
					if (cif.cyc_start) begin
						state_q <= STC_CHARGE;
					end
				end
				default: state_q <= STC_CHARGE;
			endcase
		end
	end
	assign cif.state = state_q;
	assign cif.trip  = trip_q;

	charge_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == STC_CHARGE && trip_q && cif.osc_tick |=> state_q == STC_FAST)
		else $error("charge did not end on trip");
	charge_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == STC_CHARGE && !trip_q |=> state_q == STC_CHARGE)
		else $error("charge left without trip");
	slow_rest_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == STC_SLOW && !cif.cyc_start |=> state_q == STC_SLOW)
		else $error("slow decay cut before cycle end");
	fast_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == STC_FAST && cif.decay_sel == STC_FAST_ONLY && !cif.cyc_start
		|=> state_q == STC_FAST)
		else $error("fast-only decay fell into slow");
	mix_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == STC_SLOW |-> $past(state_q) != STC_CHARGE)
		else $error("slow decay entered straight from charge");
	extend_c: cover property (@(posedge hclk) disable iff (!hresetn)
		state_q == STC_CHARGE && cif.cyc_start ##1 state_q == STC_CHARGE);
endmodule

// ===== stc_top.sv
// stepper angle, torque and decay control with an ahb-lite register slave
`timescale 1ns/1ps
`include "stc_map.svh"
module stc_top
	import stc_pkg::*;
#(
	parameter int OSC_DIV = 8
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        step_clock,
	input  wire logic        angle_reset,
	input  wire logic [9:0]  sense_int_a,
	input  wire logic [9:0]  sense_int_b,
	input  wire logic [9:0]  sense_ext_a,
	input  wire logic [9:0]  sense_ext_b,
	output logic             angle_origin_flag,
	output logic             chop_oscillator_clock,
	output logic             sense_method_select,
	output logic [1:0]       drive_state_a,
	output logic [1:0]       drive_state_b,
	output logic             phase_neg_a,
	output logic             phase_neg_b,
	output logic [1:0]       current_limit_trip,
	output logic [9:0]       target_code_a,
	output logic [9:0]       target_code_b
);
	localparam int RST_FILT_CYC = (`STC_RST_FILT_NS * `STC_CLK_MHZ + 999) / 1000;
	localparam int CHOP_CYC     = `STC_CHOP_TICKS * OSC_DIV;

	generate
		if (OSC_DIV < 2 || OSC_DIV > 255) begin : g_bad_div
			$error("OSC_DIV must lie in 2..255");
		end
	endgenerate

	// torque select to percent
	function automatic logic [6:0] stc_torque_pct(input logic [2:0] sel);
		case (sel)
			3'h0: stc_torque_pct = 7'h64;
			3'h1: stc_torque_pct = 7'h55;
			3'h2: stc_torque_pct = 7'h46;
			3'h3: stc_torque_pct = 7'h3C;
			3'h4: stc_torque_pct = 7'h32;
			3'h5: stc_torque_pct = 7'h28;
			3'h6: stc_torque_pct = 7'h19;
			default: stc_torque_pct = 7'h0A;
		endcase
	endfunction

	// step current times torque, to full code, halved by the 1/10 reference gain
	function automatic logic [9:0] stc_target(input logic [6:0] mag, input logic [6:0] tq,
			input logic gain_hi);
		logic [23:0] prod;
		prod = 24'(14'(mag) * 14'(tq)) * `STC_CODE_FULL / `STC_PCT_SQ;
		stc_target = gain_hi ? 10'(prod >> 1) : 10'(prod);
	endfunction

	// ---------------- bus slave ----------------
	logic [11:0] ctrl_q;
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic        addr_ok;
	logic        ctrl_wr;
	logic [31:0] status_w;
	logic [31:0] target_w;
	logic [31:0] rd_mux;
	logic [11:0] ctrl_view;

	assign addr_ok   = hsel && htrans[1] && hready;
	assign ctrl_wr   = wr_pend_q && wr_addr_q == `STC_CTRL_ADDR;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// address phase captured here, write lands in the data phase that follows
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	// control register; all selects live here
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `STC_CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_q <= hwdata[11:0];
		end
	end

	// a read right behind a write to control sees the new value, not the stale one
	assign ctrl_view = ctrl_wr ? hwdata[11:0] : ctrl_q;
	always_comb begin
		case (haddr[7:0])
			`STC_CTRL_ADDR: rd_mux = {20'h0_0000, ctrl_view};
			`STC_STAT_ADDR: rd_mux = status_w;
			`STC_TGT_ADDR:  rd_mux = target_w;
			default:        rd_mux = 32'h0000_0000;
		endcase
	end

	// read data registered at the address phase so it stands through the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			hrdata <= rd_mux;
		end
	end

	// ---------------- pin synchronisers ----------------
	logic        step_s1_q;
	logic        step_s2_q;
	logic        step_s3_q;
	logic        rst_s1_q;
	logic        rst_s2_q;
	logic [9:0]  sense_s1_q [4];
	logic [9:0]  sense_s2_q [4];
	logic [9:0]  sense_raw  [4];

	assign sense_raw[0] = sense_int_a;
	assign sense_raw[1] = sense_int_b;
	assign sense_raw[2] = sense_ext_a;
	assign sense_raw[3] = sense_ext_b;

	// two flops before any logic; step gets a third for edge detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			step_s1_q <= 1'b0;
			step_s2_q <= 1'b0;
			step_s3_q <= 1'b0;
			rst_s1_q  <= 1'b0;
			rst_s2_q  <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				sense_s1_q[i] <= 10'h000;
				sense_s2_q[i] <= 10'h000;
			end
		end else begin
			step_s1_q <= step_clock;
			step_s2_q <= step_s1_q;
			step_s3_q <= step_s2_q;
			rst_s1_q  <= angle_reset;
			rst_s2_q  <= rst_s1_q;
			for (int i = 0; i < 4; i++) begin
				sense_s1_q[i] <= sense_raw[i];
				sense_s2_q[i] <= sense_s1_q[i];
			end
		end
	end

	// ---------------- reset filter ----------------
	logic       rst_act_q;
	logic [5:0] filt_q;

	// a level change must persist the whole filter time before it is taken
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_act_q <= 1'b0;
			filt_q    <= 6'h00;
		end else if (rst_s2_q == rst_act_q) begin
			filt_q <= 6'h00;
		end else if (filt_q == 6'(RST_FILT_CYC - 1)) begin
			rst_act_q <= rst_s2_q;
			filt_q    <= 6'h00;
		end else begin
			filt_q <= filt_q + 6'h01;
		end
	end

	// ---------------- step edges and angle ----------------
	logic       step_rise;
	logic       step_fall;
	logic       step_ev;
	logic [8:0] angle_q;
	logic [8:0] step_inc;
	logic [2:0] res;

	assign res       = ctrl_q[`STC_F_RES];
	assign step_rise = step_s2_q && !step_s3_q;
	assign step_fall = !step_s2_q && step_s3_q;
	assign step_ev   = step_rise || (ctrl_q[`STC_F_EDGE] && step_fall);
	assign step_inc  = (res == 3'h0) ? `STC_FULL_STEP_INC : (9'h001 << (3'h7 - res));

	// electrical angle in 1/128-step units over a full electrical turn
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			angle_q <= `STC_ANGLE_INIT;
		end else if (rst_act_q) begin
			angle_q <= `STC_ANGLE_INIT;
		end else if (step_ev) begin
			angle_q <= ctrl_q[`STC_F_DIR] ? angle_q - step_inc : angle_q + step_inc;
		end
	end

	// origin monitor: high at the initial angle, forced low while reset is held
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			angle_origin_flag <= 1'b0;
		end else begin
			angle_origin_flag <= !rst_act_q && angle_q == `STC_ANGLE_INIT;
		end
	end

	// ---------------- current targets ----------------
	logic [6:0] mag_a;
	logic [6:0] mag_b;
	logic       neg_a;
	logic       neg_b;
	logic [6:0] tq_pct;

	stc_step_table u_table (
		.angle (angle_q),
		.res   (res),
		.mag_a (mag_a),
		.mag_b (mag_b),
		.neg_a (neg_a),
		.neg_b (neg_b)
	);

	assign tq_pct = stc_torque_pct(ctrl_q[`STC_F_TORQUE]);

	// targets and polarities refresh every cycle from angle, torque and gain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			target_code_a <= 10'h000;
			target_code_b <= 10'h000;
			phase_neg_a   <= 1'b0;
			phase_neg_b   <= 1'b0;
		end else begin
			target_code_a <= stc_target(mag_a, tq_pct, ctrl_q[`STC_F_GAIN]);
			target_code_b <= stc_target(mag_b, tq_pct, ctrl_q[`STC_F_GAIN]);
			phase_neg_a   <= neg_a;
			phase_neg_b   <= neg_b;
		end
	end

	// ---------------- chopping oscillator ----------------
	logic [7:0] div_q;
	logic [3:0] tick_cnt_q;
	logic       osc_tick;
	logic       cyc_start;

	assign osc_tick  = div_q == 8'(OSC_DIV - 1);
	assign cyc_start = osc_tick && tick_cnt_q == 4'(`STC_CHOP_TICKS - 1);

	// divider forms the oscillator clock; sixteen of its periods make one cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q                 <= 8'h00;
			tick_cnt_q            <= 4'h0;
			chop_oscillator_clock <= 1'b0;
		end else begin
			div_q                 <= osc_tick ? 8'h00 : div_q + 8'h01;
			tick_cnt_q            <= osc_tick ? tick_cnt_q + 4'h1 : tick_cnt_q;
			chop_oscillator_clock <= div_q < 8'(OSC_DIV / 2);
		end
	end

	// ---------------- channel choppers ----------------
	stc_chop_if chop_bus [2] ();
	logic [9:0] tgt_arr [2];

	assign tgt_arr[0] = target_code_a;
	assign tgt_arr[1] = target_code_b;

	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_ch
			assign chop_bus[ch].target    = tgt_arr[ch];
			// one sensing path chosen for both channels: internal detect or external resistor
			assign chop_bus[ch].sense     = ctrl_q[`STC_F_SENSE] ? sense_s2_q[ch + 2]
				: sense_s2_q[ch];
			assign chop_bus[ch].decay_sel = stc_decay_t'(ctrl_q[`STC_F_DECAY]);
			assign chop_bus[ch].osc_tick  = osc_tick;
			assign chop_bus[ch].cyc_start = cyc_start;
			assign current_limit_trip[ch] = chop_bus[ch].trip;
			stc_chopper u_chop (
				.hclk    (hclk),
				.hresetn (hresetn),
				.cif     (chop_bus[ch])
			);
		end
	endgenerate

	assign drive_state_a       = chop_bus[0].state;
	assign drive_state_b       = chop_bus[1].state;
	assign sense_method_select = ctrl_q[`STC_F_SENSE];

	assign status_w = {17'h0_0000, drive_state_b, drive_state_a, rst_act_q,
		angle_origin_flag, angle_q};
	assign target_w = {6'h00, target_code_b, 6'h00, target_code_a};

	// ---------------- checks ----------------
	logic [11:0] cyc_len_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc_len_q <= 12'h000;
		end else begin
			cyc_len_q <= cyc_start ? 12'h000 : cyc_len_q + 12'h001;
		end
	end

	reset_angle_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rst_act_q |=> angle_q == `STC_ANGLE_INIT)
		else $error("angle not held at initial position");
	reset_filter_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$changed(rst_act_q) |-> $past(filt_q) == 6'(RST_FILT_CYC - 1))
		else $error("reset level taken before filter time");
	origin_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rst_act_q |=> !angle_origin_flag)
		else $error("origin flag high during reset");
	single_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!rst_act_q && !ctrl_q[`STC_F_EDGE] && step_fall |=> angle_q == $past(angle_q))
		else $error("falling edge stepped in single-edge mode");
	step_move_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!rst_act_q && step_ev && !ctrl_q[`STC_F_DIR]
		|=> angle_q == $past(angle_q) + $past(step_inc))
		else $error("accepted step did not move angle one position");
	chop_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cyc_start && $past(cyc_start, 1) == 1'b0 && cyc_len_q != 12'h000
		|-> cyc_len_q == 12'(CHOP_CYC - 1))
		else $error("chopping cycle length wrong");
	torque_scale_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_q[`STC_F_TORQUE] == 3'h7 |=> target_code_a <= 10'h067)
		else $error("10 percent torque not applied");

	dual_edge_c: cover property (@(posedge hclk) disable iff (!hresetn)
		ctrl_q[`STC_F_EDGE] && step_fall && !rst_act_q);
	reset_taken_c: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(rst_act_q));
	glitch_c: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(rst_s2_q) ##1 !rst_s2_q && !rst_act_q);
endmodule

// ===== stc_host_model.sv
// host controller model: drives the step clock and angle reset pins
`timescale 1ns/1ps
module stc_host_model (
	input  wire logic hclk,
	output logic      step_clock,
	output logic      angle_reset
);
	// both pins start low; angle reset rests low between commands, step clock keeps the level of its last edge
	initial begin
		step_clock = 1'b0;
		angle_reset = 1'b0;
	end
	// one level change, held hold cycles; under 2 the synchroniser could miss it
	task automatic edge_step(input int hold);
		@(posedge hclk);
		step_clock <= ~step_clock;
		repeat (hold) @(posedge hclk);
	endtask
	// angle reset pulse of len cycles; short pulses must be filtered out
	task automatic reset_pulse(input int len);
		@(posedge hclk);
		angle_reset <= 1'b1;
		repeat (len) @(posedge hclk);
		angle_reset <= 1'b0;
	endtask
endmodule

// ===== stepper_angle_and_decay_control_tb.sv
// self-checking bench of the stepper control block against an integer model
`timescale 1ns/1ps
module stepper_angle_and_decay_control_tb;
	import stc_pkg::*;
	localparam int OSCD = 2;
	logic        hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, current_limit_trip, drive_state_a;
	logic [2:0]  hsize;
	logic        hreadyout, step_clock, angle_reset, sense_method_select;
	logic        angle_origin_flag, phase_neg_a, hresp;
	logic [9:0]  sense_int_a, sense_int_b, sense_ext_a, sense_ext_b, s;
	logic [9:0]  target_code_a, target_code_b;
	int          failures, check_count, seed, ang, e, fm, sl, ch, pr, k;
	int          pct[8] = '{100, 85, 70, 60, 50, 40, 25, 10};

	stc_top #(.OSC_DIV(OSCD)) i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .step_clock(step_clock),
		.angle_reset(angle_reset), .sense_int_a(sense_int_a), .sense_int_b(sense_int_b),
		.sense_ext_a(sense_ext_a), .sense_ext_b(sense_ext_b),
		.angle_origin_flag(angle_origin_flag), .chop_oscillator_clock(),
		.sense_method_select(sense_method_select), .drive_state_a(drive_state_a),
		.drive_state_b(), .phase_neg_a(phase_neg_a), .phase_neg_b(),
		.current_limit_trip(current_limit_trip), .target_code_a(target_code_a),
		.target_code_b(target_code_b)
	);
	stc_host_model i_host (
		.hclk(hclk),
		.step_clock(step_clock),
		.angle_reset(angle_reset)
	);

	// free-running bus clock
	always #10 hclk = ~hclk;

	// single word transfer; the slave's hready decides when each phase ends
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rdat);
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdat = hrdata;
		chk(32'(hresp), 32'h0, "hresp okay");
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// watch channel A: longest fast run, slow and charge counts, fast start period
	task automatic measure(output int fmax, output int slow_n, output int chg_n,
			output int per);
		int run, last;
		run = 0;
		last = -1;
		fmax = 0;
		slow_n = 0;
		chg_n = 0;
		per = 0;
		repeat (32 * OSCD) @(posedge hclk);
		for (int i = 0; i < 64 * OSCD; i++) begin
			@(posedge hclk);
			run = (drive_state_a === STC_FAST) ? run + 1 : 0;
			if (run == 1) begin
				if (last >= 0) per = i - last;
				last = i;
			end
			if (run > fmax) fmax = run;
			if (drive_state_a === STC_SLOW) slow_n++;
			if (drive_state_a === STC_CHARGE) chg_n++;
		end
	endtask

	task automatic test_done;
		if (failures == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// hang guard, far above the under 1500 cycles the sequence needs
	initial begin
		repeat (20000) @(posedge hclk);
		failures++;
		test_done();
	end

	// main sequence
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b1;
		hsize = 3'b010;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		{sense_int_a, sense_int_b, sense_ext_a, sense_ext_b} = 40'h00_0000_0000;
		seed = 35;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 8'h00, 32'h0, rd);
		chk(rd, 32'h0000_0000, "ctrl reset");
		bus(1'b0, 8'h04, 32'h0, rd);
		chk(rd & 32'h0000_07FF, 32'h0000_0240, "status reset");
		chk(32'(angle_origin_flag), 32'h1, "origin pin");
		bus(1'b1, 8'h08, 32'h0, rd);
		bus(0, 8'h08, 32'h0, rd);
		chk(rd, 32'h03FF_03FF, "full step target");
		bus(1'b0, 8'h0C, 32'h0, rd);
		chk(rd, 32'h0000_0000, "unmapped read");
		// every torque code with both reference gains
		for (int g = 0; g < 2; g++) begin
			for (int t = 0; t < 8; t++) begin
				bus(1'b1, 8'h00, 32'(g * 256 + t * 8), rd);
				repeat (3) @(posedge hclk);
				bus(1'b0, 8'h08, 32'h0, rd);
				e = (pct[t] * 1023 / 100) >> g;
				chk(rd, 32'(e * 65537), "torque target");
				chk(32'({target_code_b, target_code_a}), 32'(e * 1025), "target pins");
			end
		end
		// rising edge only, then both edges, then the finest resolution
		ang = 64;
		bus(1'b1, 8'h00, 32'h0000_0000, rd);
		i_host.edge_step(4);
		i_host.edge_step(6);
		ang = ang + 128;
		bus(1'b0, 8'h04, 32'h0, rd);
		chk(rd & 32'h0000_01FF, 32'(ang), "single edge");
		chk(32'(phase_neg_a), 32'(ang > 127 && ang < 384), "phase a");
		bus(1'b1, 8'h00, 32'h0000_0040, rd);
		i_host.edge_step(20);
		i_host.edge_step(6);
		ang = (ang + 256) % 512;
		bus(1'b0, 8'h04, 32'h0, rd);
		chk(rd & 32'h0000_01FF, 32'(ang), "dual edge");
		bus(1'b1, 8'h00, 32'h0000_0007, rd);
		i_host.edge_step(3);
		i_host.edge_step(6);
		ang = ang + 1;
		bus(1'b0, 8'h04, 32'h0, rd);
		chk(rd & 32'h0000_01FF, 32'(ang), "fine step");
		// reverse direction at the finest resolution
		bus(1'b1, 8'h00, 32'h0000_0807, rd);
		i_host.edge_step(3);
		i_host.edge_step(6);
		ang = ang - 1;
		bus(1'b0, 8'h04, 32'h0, rd);
		chk(rd & 32'h0000_01FF, 32'(ang), "reverse step");
		chk(32'(phase_neg_a), 32'(ang > 127 && ang < 384), "phase a");
		// a short reset pulse is dropped, a long one restores the origin
		bus(1'b1, 8'h00, 32'h0000_0001, rd);
		i_host.reset_pulse(10);
		repeat (40) @(posedge hclk);
		bus(1'b0, 8'h04, 32'h0, rd);
		chk(rd & 32'h0000_07FF, 32'(ang), "short reset");
		i_host.reset_pulse(50);
		bus(1'b0, 8'h04, 32'h0, rd);
		chk(rd & 32'h0000_07FF, 32'h0000_0440, "in reset");
		chk(32'(angle_origin_flag), 32'h0, "origin pin in reset");
		bus(1'b0, 8'h08, 32'h0, rd);
		chk(rd, 32'(726 * 65537), "half step reset");
		repeat (40) @(posedge hclk);
		bus(1'b0, 8'h04, 32'h0, rd);
		chk(rd & 32'h0000_07FF, 32'h0000_0240, "after reset");
		// trip threshold at 10% torque, target 102, boundary then random codes
		bus(1'b1, 8'h00, 32'h0000_0038, rd);
		for (int i = 0; i < 8; i++) begin
			s = (i < 2) ? 10'(101 + i) : 10'($random(seed));
			sense_int_a <= s;
			sense_int_b <= s;
			repeat (5) @(posedge hclk);
			e = (s >= 10'd102) ? 3 : 0;
			chk(32'(current_limit_trip), 32'(e), "trip");
		end
		// every decay mode with the current always above target
		sense_int_a <= 10'h3FF;
		for (int d = 0; d < 4; d++) begin
			bus(1'b1, 8'h00, 32'(d * 512 + 56), rd);
			measure(fm, sl, ch, pr);
			chk(32'(pr), 32'(16 * OSCD), "chop period");
			if (d < 2) chk(32'(fm), 32'((6 + 2 * d) * OSCD), "fast length");
			if (d < 2) chk(32'(sl > 0), 32'h1, "slow fill");
			if (d >= 2) chk(32'(sl), 32'h0, "no slow");
		end
		// current never reaches target: charge runs across cycles, then ends on trip
		bus(1'b1, 8'h00, 32'h0000_0038, rd);
		sense_int_a <= 10'h000;
		measure(fm, sl, ch, pr);
		chk(32'(ch), 32'(64 * OSCD), "charge extend");
		sense_int_a <= 10'h3FF;
		k = 0;
		while (drive_state_a !== STC_FAST && k < 12) begin
			@(posedge hclk);
			k++;
		end
		chk(32'(k < 12), 32'h1, "charge ends on trip");
		// external sense path selected
		bus(1'b1, 8'h00, 32'h0000_00B8, rd);
		{sense_int_a, sense_int_b, sense_ext_a, sense_ext_b} <= 40'h00_000F_FFFF;
		repeat (5) @(posedge hclk);
		chk(32'({sense_method_select, current_limit_trip}), 32'h7, "ext sense");
		{sense_int_a, sense_int_b, sense_ext_a, sense_ext_b} <= 40'hFF_FFF0_0000;
		repeat (5) @(posedge hclk);
		chk(32'({sense_method_select, current_limit_trip}), 32'h4, "int ignored");
		test_done();
	end
endmodule
